// [rtl/ctimer_core.sv]
// Operation
// R1: interval start latches data; match reloads latch, clears counter, keeps counting
// R2: interval mode ignores software writes of zero to the data register
// R3: interval and PWM reads of data register return the live counter
// R4: fixed PWM starts high, match drives low, overflow reloads and restarts
// R5: variable PWM low byte sets low width, high byte sets period
// R6: pulse-width completion copies counter to data register, sets buffer full
// R7: data read clears buffer full; no new result transfers while set
// R8: function 0b1001 transfers high result despite buffer full, not cycle result
// R9: writes in measure or capture modes overwrite the stored result
// R10: capture copies counter to data register on the selected edge
// R11: software writes high byte first, then low byte, in 16-bit mode
// R12: paired read of high byte snapshots low byte into a read buffer
// R13: paired write of high byte buffers; low write commits both bytes
// R14: software stops timer and clears flags before changing function select
// R15: both-edge capture started high ignores first falling edge and flag
// R16: that first fall neither clears counter nor transfers; capture starts at rise
// R17: software writes high byte before low byte in 8-bit variable PWM
// R18: counter freezes in standby and resumes from held value on wake; pin edges still clear it in pulse-width and clear-mode capture
// R19: width select zero gives two 8-bit timers, one gives 16-bit
// R20: starting variable PWM clears width select automatically
// R21: counters step once per count tick; high byte carries from low wrap in 16-bit and pulse-width modes, else steps every tick
`timescale 1ns/1ps
module ctimer_core import ctimer_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // pins and system
   input wire logic pulse_in_i,
   input wire logic count_in_i,
   input wire logic standby_i,
   output logic [1:0] timer_out_o
);
   ctrl_t ctrl;
   ctrl_t next_ctrl;
   logic [7:0] dr_lo;
   logic [7:0] dr_hi;
   logic [7:0] wbuf;
   logic [7:0] rbuf;
   logic [15:0] cnt;
   logic [15:0] latch;
   logic bf;
   logic done;
   logic run_q;
   logic skip_fall;
   logic [1:0] tout;
   meas_t meas;
   logic [7:0] next_dr_lo;
   logic [7:0] next_dr_hi;
   logic [7:0] next_wbuf;
   logic [7:0] next_rbuf;
   logic [15:0] next_cnt;
   logic [15:0] next_latch;
   logic next_bf;
   logic next_done;
   logic next_skip_fall;
   logic [1:0] next_tout;
   meas_t next_meas;
   logic [31:0] next_dat;
   logic next_ack;

   logic tick;
   edge_t pin;
   logic req;
   logic wr;
   logic rd;
   logic wide;
   logic paired;
   logic live;
   logic interval;
   logic [3:0] f;
   logic [7:0] wd;
   logic [15:0] view;
   logic [31:0] rval;
   logic tr;
   logic force_tr;
   logic beg;
   logic hit;

   ctimer_tick u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(ctrl.run_control),
      .hold_i(standby_i), // R18
      .clk_sel_i(ctrl.clk_sel),
      .pulse_in_i(pulse_in_i),
      .count_in_i(count_in_i),
      .tick_o(tick),
      .pin_o(pin)
   );

   // decode and read mux
   always_comb begin
      f = ctrl.func;
      wide = ctrl.width_select;
      paired = wide || f == F_PWM_VAR;
      live = !is_pwc(f) && !is_cap(f);
      interval = f == F_INTERVAL;
      req = cyc_i && stb_i && !ack_o;
      wr = req && we_i && sel_i[0];
      rd = req && !we_i;
      wd = dat_i[7:0];
      view = live ? cnt : {dr_hi, dr_lo}; // R3
      rval = RDAT_RST;
      unique case (adr_i)
         OFS_LO: rval[7:0] = paired ? rbuf : view[7:0]; // R12
         OFS_HI: rval[7:0] = view[15:8];
         OFS_CTRL: rval[$bits(ctrl_t)-1:0] = ctrl;
         OFS_STAT: rval[ST_OUT+1:0] = {tout, done, bf};
         default: rval = RDAT_RST;
      endcase
      next_ack = req;
      next_dat = (req && !we_i) ? rval : RDAT_RST;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= RDAT_RST;
      end else begin
         ack_o <= next_ack;
         dat_o <= next_dat;
      end
   end

   // timer core
   always_comb begin
      next_ctrl = ctrl;
      next_dr_lo = dr_lo;
      next_dr_hi = dr_hi;
      next_wbuf = wbuf;
      next_rbuf = rbuf;
      next_cnt = cnt;
      next_latch = latch;
      next_bf = bf;
      next_done = done;
      next_skip_fall = skip_fall;
      next_tout = tout;
      next_meas = meas;
      tr = 1'b0;
      force_tr = 1'b0;
      beg = 1'b0;
      hit = 1'b0;

      // software side first so that hardware events below win
      if (wr) begin
         unique case (adr_i)
            OFS_LO: begin
               if (paired) begin
                  if (!(interval && wd == BYTE_ZERO && wbuf == BYTE_ZERO)) begin // R2
                     next_dr_lo = wd; // R13 R9
                     next_dr_hi = wbuf; // R13
                  end
               end else if (!(interval && wd == BYTE_ZERO)) begin // R2
                  next_dr_lo = wd; // R9
               end
            end
            OFS_HI: begin
               if (paired) begin
                  next_wbuf = wd; // R13
               end else if (!(interval && wd == BYTE_ZERO)) begin // R2
                  next_dr_hi = wd; // R9
               end
            end
            OFS_CTRL: begin
               next_ctrl = ctrl_t'(dat_i[$bits(ctrl_t)-1:0]);
               if (ctrl.run_control) begin
                  next_ctrl.width_select = ctrl.width_select;
               end
            end
            OFS_STAT: begin
               if (dat_i[ST_BF]) begin
                  next_bf = 1'b0;
               end
               if (dat_i[ST_DONE]) begin
                  next_done = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (rd && adr_i == OFS_HI && paired) begin
         next_rbuf = view[7:0]; // R12
      end
      if (rd && adr_i == OFS_LO) begin
         next_bf = 1'b0; // R7
      end

      if (ctrl.run_control && !run_q) begin
         next_latch = {dr_hi, dr_lo}; // R1 R4 R5
         next_cnt = CNT_ZERO;
         next_tout = (f == F_PWM_FIX) ? 2'b11 : 2'b00; // R4 R5
         next_meas = M_IDLE;
         next_skip_fall = pin.level && (f == F_CAP_BOTH || f == F_CAP_BOTH_ALT); // R15
         if (f == F_PWM_VAR && wide) begin
            next_ctrl.width_select = 1'b0; // R20
         end
      end else if (ctrl.run_control) begin
         unique case (f)
            F_INTERVAL: begin
               if (tick && wide) begin // R19
                  if (cnt == latch) begin
                     next_cnt = CNT_ZERO; // R1
                     next_latch = {dr_hi, dr_lo}; // R1
                     next_tout[0] = !tout[0];
                  end else begin
                     next_cnt = inc16(cnt, 1'b1); // R21
                  end
               end else if (tick) begin
                  for (int h = 0; h < 2; h++) begin
                     if (cnt[h*8 +: 8] == latch[h*8 +: 8]) begin
                        next_cnt[h*8 +: 8] = BYTE_ZERO; // R1
                        next_latch[h*8 +: 8] = h == 0 ? dr_lo : dr_hi; // R1
                        next_tout[h] = !tout[h];
                     end else begin
                        next_cnt[h*8 +: 8] = cnt[h*8 +: 8] + 8'h01; // R21
                     end
                  end
               end
            end
            F_PWM_FIX: begin
               if (tick && wide) begin
                  if (cnt == latch) begin
                     next_tout = 2'b00; // R4
                  end
                  if (cnt == CNT_TOP) begin
                     next_cnt = CNT_ZERO;
                     next_latch = {dr_hi, dr_lo}; // R4
                     next_tout = 2'b11;
                  end else begin
                     next_cnt = inc16(cnt, 1'b1);
                  end
               end else if (tick) begin
                  for (int h = 0; h < 2; h++) begin
                     if (cnt[h*8 +: 8] == latch[h*8 +: 8]) begin
                        next_tout[h] = 1'b0; // R4
                     end
                     next_cnt[h*8 +: 8] = cnt[h*8 +: 8] + 8'h01;
                     if (cnt[h*8 +: 8] == BYTE_TOP) begin
                        next_latch[h*8 +: 8] = h == 0 ? dr_lo : dr_hi; // R4
                        next_tout[h] = 1'b1;
                     end
                  end
               end
            end
            F_PWM_VAR: begin
               if (tick) begin
                  next_cnt = inc16(cnt, 1'b0); // R21
                  if (cnt[7:0] == latch[7:0]) begin
                     next_tout = 2'b11; // R5
                  end
                  if (cnt[15:8] == latch[15:8]) begin
                     next_cnt = CNT_ZERO; // R5
                     next_latch = {dr_hi, dr_lo}; // R5
                     next_tout = 2'b00;
                  end
               end
            end
            F_PWC_HIGH, F_PWC_LOW, F_PWC_CYC, F_PWC_HCYC: begin
               unique case (f)
                  F_PWC_HIGH: begin
                     tr = pin.fall && meas == M_ACTIVE;
                     beg = pin.rise;
                  end
                  F_PWC_LOW: begin
                     tr = pin.rise && meas == M_ACTIVE;
                     beg = pin.fall;
                  end
                  F_PWC_CYC: begin
                     tr = pin.rise && meas == M_ACTIVE;
                     beg = pin.rise;
                  end
                  default: begin
                     // high result on fall, cycle result on the next rise
                     tr = (pin.fall || pin.rise) && meas == M_ACTIVE;
                     force_tr = pin.fall; // R8
                     beg = pin.rise;
                  end
               endcase
               if (tr) begin
                  next_done = 1'b1;
                  if (!bf || force_tr) begin // R7 R8
                     next_dr_lo = cnt[7:0]; // R6
                     next_dr_hi = wide ? cnt[15:8] : next_dr_hi; // R6
                     next_bf = 1'b1; // R6
                  end
               end
               if (beg) begin
                  next_cnt = CNT_ZERO;
                  next_meas = M_ACTIVE;
               end else if (tr && (f == F_PWC_HIGH || f == F_PWC_LOW)) begin
                  next_meas = M_IDLE;
               end else if (tick && meas == M_ACTIVE) begin
                  next_cnt = inc16(cnt, 1'b1);
               end
            end
            F_CAP_BOTH, F_CAP_RISE, F_CAP_FALL, F_CAP_BOTH_ALT: begin
               hit = (pin.rise && f != F_CAP_FALL) || (pin.fall && f != F_CAP_RISE);
               if (skip_fall && pin.fall) begin
                  hit = 1'b0; // R15 R16
               end
               if (pin.rise) begin
                  next_skip_fall = 1'b0; // R16
               end
               if (hit) begin
                  next_dr_lo = cnt[7:0]; // R10
                  next_dr_hi = wide ? cnt[15:8] : next_dr_hi; // R10
                  next_done = 1'b1;
                  next_bf = 1'b1;
               end
               if (hit && ctrl.clear_mode) begin
                  next_cnt = CNT_ZERO;
               end else if (tick) begin
                  next_cnt = inc16(cnt, wide); // R21
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RST;
         dr_lo <= DATA_RST;
         dr_hi <= DATA_RST;
         wbuf <= DATA_RST;
         rbuf <= DATA_RST;
         cnt <= CNT_ZERO;
         latch <= CNT_ZERO;
         bf <= 1'b0;
         done <= 1'b0;
         run_q <= 1'b0;
         skip_fall <= 1'b0;
         tout <= 2'b00;
         meas <= M_IDLE;
      end else begin
         ctrl <= next_ctrl;
         dr_lo <= next_dr_lo;
         dr_hi <= next_dr_hi;
         wbuf <= next_wbuf;
         rbuf <= next_rbuf;
         cnt <= next_cnt;
         latch <= next_latch;
         bf <= next_bf;
         done <= next_done;
         run_q <= ctrl.run_control;
         skip_fall <= next_skip_fall;
         tout <= next_tout;
         meas <= next_meas;
      end
   end

   assign timer_out_o = tout;

endmodule : ctimer_core

// [rtl/ctimer_pkg.sv]
package ctimer_pkg;

   // byte offsets on the bus, decoded from adr_i[3:0]
   localparam logic [3:0] OFS_LO = 4'h0;
   localparam logic [3:0] OFS_HI = 4'h4;
   localparam logic [3:0] OFS_CTRL = 4'h8;
   localparam logic [3:0] OFS_STAT = 4'hC;

   // function select codes
   localparam logic [3:0] F_INTERVAL = 4'h0;
   localparam logic [3:0] F_PWM_FIX = 4'h1;
   localparam logic [3:0] F_PWM_VAR = 4'h2;
   localparam logic [3:0] F_PWC_HIGH = 4'h8;
   localparam logic [3:0] F_PWC_HCYC = 4'h9;
   localparam logic [3:0] F_PWC_LOW = 4'hA;
   localparam logic [3:0] F_PWC_CYC = 4'hB;
   localparam logic [3:0] F_CAP_BOTH = 4'hC;
   localparam logic [3:0] F_CAP_RISE = 4'hD;
   localparam logic [3:0] F_CAP_FALL = 4'hE;
   localparam logic [3:0] F_CAP_BOTH_ALT = 4'hF;

   // reset values and counter limits
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_TOP = 8'hFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_TOP = 16'hFFFF;
   localparam logic [31:0] RDAT_RST = 32'h0000_0000;

   // status register bit positions
   localparam int ST_BF = 0;
   localparam int ST_DONE = 1;
   localparam int ST_OUT = 2;

   // count clock select and divider terminal counts
   localparam logic [1:0] CS_DIV1 = 2'h0;
   localparam logic [1:0] CS_DIV2 = 2'h1;
   localparam logic [1:0] CS_DIV8 = 2'h2;
   localparam logic [1:0] CS_EXT = 2'h3;
   localparam logic [2:0] DIV2_LAST = 3'h1;
   localparam logic [2:0] DIV8_LAST = 3'h7;
   localparam logic [2:0] DIV_RST = 3'h0;

   typedef struct packed {
      logic [1:0] clk_sel;
      logic clear_mode;
      logic width_select;
      logic [3:0] func;
      logic run_control;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{clk_sel: CS_DIV1, clear_mode: 1'b0, width_select: 1'b0,
                                  func: F_INTERVAL, run_control: 1'b0};

   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } edge_t;

   typedef enum logic [1:0] {
      M_IDLE = 2'b01,
      M_ACTIVE = 2'b10
   } meas_t;

   function automatic logic is_pwc(input logic [3:0] f);
      return f[3:2] == 2'b10;
   endfunction : is_pwc

   function automatic logic is_cap(input logic [3:0] f);
      return f[3:2] == 2'b11;
   endfunction : is_cap

   // carry from the low byte into the high byte only when chained
   function automatic logic [15:0] inc16(input logic [15:0] c, input logic chain);
      logic [7:0] hi;
      hi = c[15:8] + 8'h01;
      if (chain && c[7:0] != BYTE_TOP) begin
         hi = c[15:8];
      end
      return {hi, c[7:0] + 8'h01};
   endfunction : inc16

endpackage : ctimer_pkg

// [rtl/ctimer_tick.sv]
`timescale 1ns/1ps
module ctimer_tick import ctimer_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic hold_i,
   input wire logic [1:0] clk_sel_i,
   // pins
   input wire logic pulse_in_i,
   input wire logic count_in_i,
   // to the timer core
   output logic tick_o,
   output edge_t pin_o
);
   logic [2:0] p_s;
   logic [2:0] c_s;
   logic [2:0] div;
   logic [2:0] next_p_s;
   logic [2:0] next_c_s;
   logic [2:0] next_div;
   logic go;

   always_comb begin
      go = run_i && !hold_i;
      next_p_s = {p_s[1:0], pulse_in_i};
      next_c_s = {c_s[1:0], count_in_i};
      next_div = go ? div + 3'h1 : div;
      unique case (clk_sel_i)
         CS_DIV1: tick_o = go;
         CS_DIV2: tick_o = go && (div & DIV2_LAST) == DIV2_LAST;
         CS_DIV8: tick_o = go && div == DIV8_LAST;
         CS_EXT: tick_o = go && c_s[1] && !c_s[2];
      endcase
      // only the second and third stages feed logic
      pin_o.level = p_s[1];
      pin_o.rise = p_s[1] && !p_s[2];
      pin_o.fall = !p_s[1] && p_s[2];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         p_s <= 3'h0;
         c_s <= 3'h0;
         div <= DIV_RST;
      end else begin
         p_s <= next_p_s;
         c_s <= next_c_s;
         div <= next_div;
      end
   end

endmodule : ctimer_tick

// [bench/ctimer_core_chk.sv]
`timescale 1ns/1ps
module ctimer_core_chk import ctimer_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // pins and system
   input wire logic pulse_in_i,
   input wire logic count_in_i,
   input wire logic standby_i,
   input wire logic [1:0] timer_out_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence take_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   // two cycles of standby with the bus idle, so no start is still in flight
   sequence frozen_s;
      (standby_i && !(cyc_i && stb_i)) ##1 (standby_i && !(cyc_i && stb_i));
   endsequence
   ack_next_a: assert property (take_s |=> ack_o)
      else $error("no answer one cycle after a request");
   ack_single_a: assert property (ack_o |=> !ack_o)
      else $error("answer held longer than one cycle");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("answer without a request");
   idle_data_a: assert property (!ack_o |-> dat_o == RDAT_RST)
      else $error("read data outside an answer");
   unmapped_zero_a: assert property (ack_o && $past(adr_i[1:0]) != 2'h0 |-> dat_o == RDAT_RST)
      else $error("unmapped address returned data");
   data_width_a: assert property (ack_o && !$past(adr_i[3]) |-> dat_o[31:8] == 24'h000000)
      else $error("data register read wider than a byte");
   stat_width_a: assert property (ack_o && $past(adr_i) == OFS_STAT |-> dat_o[31:4] == 28'h0)
      else $error("status read carries stray bits");
   stby_hold_a: assert property (frozen_s |=> $stable(timer_out_o))
      else $error("timer output moved in standby");
   rst_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && timer_out_o == 2'h0)
      else $error("outputs not cleared by reset");
endmodule : ctimer_core_chk

// [bench/ctimer_pins.sv]
`timescale 1ns/1ps
module ctimer_pins (
   // clock
   input wire logic clk_i,
   // commands from the bench
   input wire logic level_i,
   input wire logic count_en_i,
   // pins towards the timer
   output logic pulse_o = 1'b0,
   output logic count_o = 1'b0
);
   // external count clock stands low unless asked to run
   always @(posedge clk_i) begin
      pulse_o <= level_i;
      count_o <= count_en_i && !count_o;
   end
endmodule : ctimer_pins

// [bench/tb_composite_timer_data_path.sv]
`timescale 1ns/1ps
module tb_composite_timer_data_path;
   import ctimer_pkg::*;
   typedef struct packed {
      logic [3:0] func;
      logic [3:0] adr;
      logic [7:0] wdat;
      logic [7:0] exp;
   } row_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [3:0] adr_i = 4'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic ack_o;
   logic pulse_in_i;
   logic count_in_i;
   logic standby_i = 1'b0;
   logic [1:0] timer_out_o;
   logic level = 1'b0;
   logic count_en = 1'b0;
   logic [31:0] rd;
   logic [31:0] rd2;
   int fails = 0;
   int comparisons = 0;
   int n;
   row_t rows [6] = '{'{F_PWC_HIGH, OFS_LO, 8'h5A, 8'h5A}, '{F_PWC_HIGH, OFS_HI, 8'hA5, 8'hA5},
      '{F_CAP_BOTH, OFS_LO, 8'h3C, 8'h3C}, '{F_INTERVAL, OFS_LO, 8'h77, 8'h00},
      '{F_PWM_FIX, OFS_HI, 8'h33, 8'h00}, '{F_PWC_CYC, 4'h2, 8'hFF, 8'h00}};
   logic [3:0] codes [11] = '{F_INTERVAL, F_PWM_FIX, F_PWM_VAR, F_PWC_HIGH, F_PWC_HCYC,
      F_PWC_LOW, F_PWC_CYC, F_CAP_BOTH, F_CAP_RISE, F_CAP_FALL, F_CAP_BOTH_ALT};
   always #25 clk_i = ~clk_i;
   ctimer_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .pulse_in_i(pulse_in_i), .count_in_i(count_in_i), .standby_i(standby_i),
      .timer_out_o(timer_out_o));
   ctimer_pins pins (.clk_i(clk_i), .level_i(level), .count_en_i(count_en),
      .pulse_o(pulse_in_i), .count_o(count_in_i));
   task automatic finish_test;
      if (fails == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // classic single cycle; entered just after a rising edge, leaves one idle cycle
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                     output logic [31:0] q);
      int k;
      k = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= adr;
      sel_i <= 4'hF;
      dat_i <= wd;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      q = dat_o;
      check("bus answer", 32'h1, {31'h0, ack_o});
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wr(input logic [3:0] adr, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, adr, d, q);
   endtask : wr
   task automatic rdc(input string what, input logic [3:0] adr, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, adr, RDAT_RST, q);
      check(what, exp, q);
   endtask : rdc
   function automatic logic [31:0] ctl(input logic [3:0] f, input logic wsel, input logic run,
                                       input logic [1:0] cs);
      return {23'h0, cs, 1'b0, wsel, f, run};
   endfunction : ctl
   // cycles until output 0 leaves lvl and comes back to it
   task automatic wait_to(input logic lvl, output int cyc);
      cyc = 0;
      while (timer_out_o[0] !== !lvl && cyc < 3000) begin
         @(posedge clk_i);
         cyc++;
      end
      while (timer_out_o[0] !== lvl && cyc < 3000) begin
         @(posedge clk_i);
         cyc++;
      end
   endtask : wait_to
   task automatic pulse(input int w);
      level <= 1'b1;
      repeat (w) @(posedge clk_i);
      level <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask : pulse
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 4; i++) rdc("reset value", 4'(i << 2), RDAT_RST);
      foreach (codes[i]) begin
         wr(OFS_CTRL, ctl(codes[i], 1'b0, 1'b0, CS_DIV1));
         rdc("control", OFS_CTRL, ctl(codes[i], 1'b0, 1'b0, CS_DIV1));
      end
      foreach (rows[i]) begin
         wr(OFS_CTRL, ctl(rows[i].func, 1'b0, 1'b0, CS_DIV1));
         wr(rows[i].adr, {24'h0, rows[i].wdat});
         rdc("data row", rows[i].adr, {24'h0, rows[i].exp});
      end
      wr(OFS_CTRL, ctl(F_PWC_HIGH, 1'b1, 1'b0, CS_DIV1));
      wr(OFS_HI, 32'h0000_0012);
      rdc("high before commit", OFS_HI, 32'h0000_0033);
      wr(OFS_LO, 32'h0000_0034);
      rdc("paired high", OFS_HI, 32'h0000_0012);
      rdc("paired low", OFS_LO, 32'h0000_0034);
      wr(OFS_CTRL, ctl(F_INTERVAL, 1'b0, 1'b0, CS_DIV1));
      wr(OFS_LO, 32'h0000_0005);
      wr(OFS_LO, 32'h0000_0000);
      wr(OFS_CTRL, ctl(F_INTERVAL, 1'b0, 1'b1, CS_DIV1));
      wait_to(1'b1, n);
      wait_to(1'b1, n);
      check("interval period", 32'h0000_000C, 32'(n));
      wb(1'b0, OFS_LO, RDAT_RST, rd);
      check("live count", 32'h1, {31'h0, rd[7:0] <= 8'h05});
      standby_i <= 1'b1;
      @(posedge clk_i);
      wb(1'b0, OFS_LO, RDAT_RST, rd);
      repeat (10) @(posedge clk_i);
      wb(1'b0, OFS_LO, RDAT_RST, rd2);
      check("frozen count", rd, rd2);
      standby_i <= 1'b0;
      wr(OFS_CTRL, ctl(F_INTERVAL, 1'b0, 1'b0, CS_DIV1));
      wr(OFS_CTRL, ctl(F_PWM_FIX, 1'b0, 1'b0, CS_EXT));
      wr(OFS_LO, 32'h0000_0040);
      count_en <= 1'b1;
      wr(OFS_CTRL, ctl(F_PWM_FIX, 1'b0, 1'b1, CS_EXT));
      wait_to(1'b1, n);
      wait_to(1'b1, n);
      check("fixed period", 32'h0000_0200, 32'(n));
      wait_to(1'b0, n);
      // high from the overflow tick through the tick that sees the match: 0x41 ticks of 2 clocks
      check("fixed high", 32'h0000_0082, 32'(n));
      wr(OFS_CTRL, ctl(F_PWM_FIX, 1'b0, 1'b0, CS_EXT));
      count_en <= 1'b0;
      wr(OFS_CTRL, ctl(F_PWM_VAR, 1'b1, 1'b0, CS_DIV1));
      wr(OFS_HI, 32'h0000_0009);
      wr(OFS_LO, 32'h0000_0003);
      wr(OFS_CTRL, ctl(F_PWM_VAR, 1'b1, 1'b1, CS_DIV1));
      rdc("width auto clear", OFS_CTRL, ctl(F_PWM_VAR, 1'b0, 1'b1, CS_DIV1));
      wait_to(1'b1, n);
      wait_to(1'b1, n);
      check("variable period", 32'h0000_000A, 32'(n));
      wait_to(1'b0, n);
      // low lasts low byte plus one ticks, the rest of the 10-tick period is high
      check("variable high", 32'h0000_0006, 32'(n));
      wr(OFS_CTRL, ctl(F_PWM_VAR, 1'b0, 1'b0, CS_DIV1));
      wr(OFS_STAT, 32'h0000_0003);
      wr(OFS_CTRL, ctl(F_PWC_HIGH, 1'b0, 1'b0, CS_DIV1));
      wr(OFS_CTRL, ctl(F_PWC_HIGH, 1'b0, 1'b1, CS_DIV1));
      pulse(20);
      wb(1'b0, OFS_STAT, RDAT_RST, rd);
      check("full flag set", 32'h1, {31'h0, rd[ST_BF]});
      wb(1'b0, OFS_LO, RDAT_RST, rd);
      check("pulse width", 32'h1, {31'h0, rd[7:0] >= 8'h13 && rd[7:0] <= 8'h15});
      wb(1'b0, OFS_STAT, RDAT_RST, rd);
      check("full flag cleared", 32'h0, {31'h0, rd[ST_BF]});
      pulse(10);
      pulse(30);
      wb(1'b0, OFS_LO, RDAT_RST, rd);
      check("blocked result", 32'h1, {31'h0, rd[7:0] >= 8'h09 && rd[7:0] <= 8'h0B});
      wr(OFS_CTRL, ctl(F_PWC_HIGH, 1'b0, 1'b0, CS_DIV1));
      wr(OFS_STAT, 32'h0000_0003);
      level <= 1'b1;
      repeat (6) @(posedge clk_i);
      wr(OFS_CTRL, ctl(F_CAP_BOTH, 1'b0, 1'b0, CS_DIV1));
      wr(OFS_CTRL, ctl(F_CAP_BOTH, 1'b0, 1'b1, CS_DIV1));
      level <= 1'b0;
      repeat (8) @(posedge clk_i);
      wb(1'b0, OFS_STAT, RDAT_RST, rd);
      check("first fall ignored", 32'h0, {31'h0, rd[ST_DONE]});
      level <= 1'b1;
      repeat (8) @(posedge clk_i);
      wb(1'b0, OFS_STAT, RDAT_RST, rd);
      check("rise captured", 32'h1, {31'h0, rd[ST_DONE]});
      wb(1'b0, OFS_LO, RDAT_RST, rd);
      check("capture value", 32'h1, {31'h0, rd[7:0] != 8'h00});
      wr(OFS_CTRL, ctl(F_CAP_BOTH, 1'b0, 1'b0, CS_DIV1));
      wr(OFS_STAT, 32'h0000_0003);
      level <= 1'b0;
      wr(OFS_CTRL, ctl(F_PWC_HCYC, 1'b0, 1'b0, CS_DIV1));
      wr(OFS_CTRL, ctl(F_PWC_HCYC, 1'b0, 1'b1, CS_DIV1));
      // first high result leaves buffer full; the second high result must still land
      pulse(10);
      pulse(20);
      wb(1'b0, OFS_LO, RDAT_RST, rd);
      check("forced high result", 32'h1, {31'h0, rd[7:0] >= 8'h13 && rd[7:0] <= 8'h15});
      // reset in mid-run, with the timer running and the done flag set
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 4; i++) rdc("mid-run reset", 4'(i << 2), RDAT_RST);
      finish_test();
   end
endmodule : tb_composite_timer_data_path
bind ctimer_core ctimer_core_chk chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .pulse_in_i(pulse_in_i), .count_in_i(count_in_i), .standby_i(standby_i),
   .timer_out_o(timer_out_o));
